// [logic/isc_cfg.svh]
// Constants for the idle and sleep state control block
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
`define ISC_LANES 4
`define ISC_CTRLS 4
`define ISC_IFS 4
`define ISC_XTAL_USERS 2
`define ISC_IDLE_DWELL_NS 1000
`define ISC_CLK_NS 10
`define ISC_IDLE_DWELL_CYC ((`ISC_IDLE_DWELL_NS + `ISC_CLK_NS - 1) / `ISC_CLK_NS)
`define ISC_DWELL_W 8
`define ISC_CST_C0 3'h0
`define ISC_CST_C6 3'h3
`define ISC_CST_C10 3'h6
`define ISC_SLP_S3 2'h1
`define ISC_SLP_S4 2'h2
`define ISC_SLP_S5 2'h3
`endif

// [logic/isc_pkg.sv]
// Types for the idle and sleep state control block
package isc_pkg;
  typedef enum logic [2:0] {
    ISC_SYS_S0 = 3'h0,
    ISC_SYS_S3 = 3'h1,
    ISC_SYS_S4 = 3'h3,
    ISC_SYS_S5 = 3'h2,
    ISC_SYS_DEEP = 3'h6,
    ISC_SYS_MOFF = 3'h7
  } isc_sys_t;
  typedef enum logic [1:0] {
    ISC_LVL_ONE = 2'h0,
    ISC_LVL_TWO = 2'h1,
    ISC_LVL_THREE = 2'h3
  } isc_lvl_t;
  // C-state message from the processor
  typedef struct packed {
    logic valid;
    logic [2:0] cstate;
  } isc_cmsg_t;
  // Local idle reports
  typedef struct packed {
    logic [3:0] lane_lowpower;
    logic [3:0] ctrl_idle;
    logic [3:0] if_idle;
    logic [1:0] xtal_req;
  } isc_idle_t;
  // Gating outputs
  typedef struct packed {
    logic [3:0] lane_gate;
    logic [3:0] ctrl_gate;
    logic [3:0] if_pll_off;
    logic fabric_pll_off;
    logic base_clk_pll_off;
    logic xtal_off;
  } isc_gate_t;
endpackage : isc_pkg

// [logic/isc_sleep_fsm.sv]
// System sleep state tracker with deepest-suspend memory
`timescale 1ns/1ps
`default_nettype none
`include "isc_cfg.svh"
module isc_sleep_fsm (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Triggers
  input wire logic sleep_enable_bit,
  input wire logic [1:0] sleep_type,
  input wire logic wake_event,
  input wire logic power_button_override,
  input wire logic deep_enter,
  input wire logic deep_exit_ac,
  input wire logic power_fail,
  input wire logic power_return,
  input wire logic after_power_loss_select,
  input wire logic mobile_config,
  input wire logic battery_low_n,
  // State
  output isc_pkg::isc_sys_t sys_state,
  output logic full_boot
);
  import isc_pkg::*;

  isc_sys_t next_state;
  isc_sys_t deep_from;
  isc_sys_t pre_loss;
  logic wake_ok;

  // Resume to running held off by low battery in mobile systems
  assign wake_ok = wake_event && (!mobile_config || battery_low_n);

  always_comb begin
    next_state = sys_state;
    if (power_fail && sys_state != ISC_SYS_MOFF) begin
      next_state = ISC_SYS_MOFF;
    end else begin
      unique case (sys_state)
        ISC_SYS_S0: begin
          if (power_button_override) begin
            next_state = ISC_SYS_S5;
          end else if (sleep_enable_bit) begin
            unique case (sleep_type)
              `ISC_SLP_S3: next_state = ISC_SYS_S3;
              `ISC_SLP_S4: next_state = ISC_SYS_S4;
              default: next_state = ISC_SYS_S5;
            endcase
          end
        end
        ISC_SYS_S3, ISC_SYS_S4: begin
          if (wake_ok) next_state = ISC_SYS_S0;
          else if (power_button_override) next_state = ISC_SYS_S5;
          else if (deep_enter) next_state = ISC_SYS_DEEP;
        end
        ISC_SYS_S5: begin
          if (wake_ok) next_state = ISC_SYS_S0;
          else if (deep_enter) next_state = ISC_SYS_DEEP;
        end
        ISC_SYS_DEEP: begin
          if (wake_ok) next_state = ISC_SYS_S0;
          else if (deep_exit_ac) next_state = deep_from;
        end
        ISC_SYS_MOFF: begin
          // Wakes ignored; only power return counts
          if (power_return) begin
            // Prior S4 returns to S4 when selected; S0 waits battery only in mobile systems
            if (pre_loss == ISC_SYS_S4 && after_power_loss_select) begin
              next_state = ISC_SYS_S4;
            end else if (after_power_loss_select) begin
              next_state = ISC_SYS_S5;
            end else if (!mobile_config || battery_low_n) begin
              next_state = ISC_SYS_S0;
            end
          end
        end
        default: next_state = ISC_SYS_MOFF;
      endcase
    end
  end

  // Every step is direct, one state per edge
  always_ff @(posedge clk) begin
    if (!rst_n) sys_state <= ISC_SYS_MOFF;
    else sys_state <= next_state;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      deep_from <= ISC_SYS_S5;
    end else if (next_state == ISC_SYS_DEEP && sys_state != ISC_SYS_DEEP) begin
      deep_from <= sys_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_loss <= ISC_SYS_S5;
    end else if (power_fail && sys_state != ISC_SYS_MOFF) begin
      pre_loss <= sys_state;
    end
  end

  // Pulse on leaving soft-off or mechanical off for the running state
  always_ff @(posedge clk) begin
    if (!rst_n) full_boot <= 1'b0;
    else full_boot <= (sys_state == ISC_SYS_S5 || sys_state == ISC_SYS_MOFF)
      && next_state == ISC_SYS_S0;
  end
endmodule : isc_sleep_fsm
`default_nettype wire

// [logic/isc_idle_level.sv]
// Idle level grading from processor C-state messages
`timescale 1ns/1ps
`default_nettype none
`include "isc_cfg.svh"
module isc_idle_level (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire isc_pkg::isc_cmsg_t cmsg,
  input wire logic all_idle,
  input wire logic in_s0,
  // Level
  output isc_pkg::isc_lvl_t level,
  output logic [2:0] pkg_cstate
);
  import isc_pkg::*;

  isc_lvl_t next_level;

  // Only the messaged C-state is known here
  always_ff @(posedge clk) begin
    if (!rst_n) pkg_cstate <= `ISC_CST_C0;
    else if (!in_s0) pkg_cstate <= `ISC_CST_C0;
    else if (cmsg.valid) pkg_cstate <= cmsg.cstate;
  end

  always_comb begin
    next_level = ISC_LVL_ONE;
    if (in_s0 && all_idle && pkg_cstate >= `ISC_CST_C6) begin
      next_level = ISC_LVL_TWO;
      if (pkg_cstate >= `ISC_CST_C10) next_level = ISC_LVL_THREE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) level <= ISC_LVL_ONE;
    else if (next_level != level) level <= next_level;
  end
endmodule : isc_idle_level
`default_nettype wire

// [logic/isc_top.sv]
// Idle and sleep state control: gating, idle floor and sleep states
`timescale 1ns/1ps
`default_nettype none
`include "isc_cfg.svh"
module isc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor messages
  input wire isc_pkg::isc_cmsg_t cmsg,
  // Local idle reports
  input wire isc_pkg::isc_idle_t idle,
  // Sleep control
  input wire logic sleep_enable_bit,
  input wire logic [1:0] sleep_type,
  input wire logic wake_event,
  input wire logic power_button_override,
  input wire logic deep_enter,
  input wire logic deep_exit_ac,
  input wire logic power_fail,
  input wire logic power_return,
  input wire logic after_power_loss_select,
  input wire logic mobile_config,
  input wire logic battery_low_n,
  // Gating and platform outputs
  output isc_pkg::isc_gate_t gate,
  output logic idle_floor_n,
  output logic core_rail_low_voltage_mode,
  output logic ext_clk_run,
  output logic full_boot,
  output isc_pkg::isc_sys_t sys_state,
  output isc_pkg::isc_lvl_t idle_level
);
  import isc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  isc_sys_t sys_now;
  isc_lvl_t lvl_now;
  logic [2:0] pkg_cstate;
  logic all_idle;
  logic in_s0;
  logic next_fabric_off;
  logic [`ISC_DWELL_W-1:0] dwell;

  function automatic logic all_set(input logic [3:0] v);
    all_set = &v;
  endfunction : all_set

  assign in_s0 = (sys_now == ISC_SYS_S0);
  assign next_fabric_off = in_s0 && all_set(idle.ctrl_idle)
    && all_set(idle.if_idle) && all_set(idle.lane_lowpower);

  // Short dwell before fabric gating so brief idles do not thrash the PLL
  always_ff @(posedge clk) begin
    if (!rst_n) dwell <= '0;
    else if (!next_fabric_off) dwell <= '0;
    else if (dwell != `ISC_DWELL_W'(`ISC_IDLE_DWELL_CYC)) dwell <= dwell + 1'b1;
  end
  assign all_idle = (dwell == `ISC_DWELL_W'(`ISC_IDLE_DWELL_CYC));

  ////////////////////////////////////////////////////////////////////////
  isc_sleep_fsm u_sleep (
    .clk(clk),
    .rst_n(rst_n),
    .sleep_enable_bit(sleep_enable_bit),
    .sleep_type(sleep_type),
    .wake_event(wake_event),
    .power_button_override(power_button_override),
    .deep_enter(deep_enter),
    .deep_exit_ac(deep_exit_ac),
    .power_fail(power_fail),
    .power_return(power_return),
    .after_power_loss_select(after_power_loss_select),
    .mobile_config(mobile_config),
    .battery_low_n(battery_low_n),
    .sys_state(sys_now),
    .full_boot(full_boot)
  );

  isc_idle_level u_level (
    .clk(clk),
    .rst_n(rst_n),
    .cmsg(cmsg),
    .all_idle(all_idle),
    .in_s0(in_s0),
    .level(lvl_now),
    .pkg_cstate(pkg_cstate)
  );

  ////////////////////////////////////////////////////////////////////////
  // Local gating is autonomous in every idle level
  // One process owns the whole gate word, so it has a single driver
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate <= '0;
    end else begin
      gate.lane_gate <= idle.lane_lowpower;
      gate.ctrl_gate <= idle.ctrl_idle;
      gate.if_pll_off <= idle.if_idle;
      gate.fabric_pll_off <= lvl_now != ISC_LVL_ONE && all_idle;
      gate.base_clk_pll_off <= lvl_now != ISC_LVL_ONE && all_idle
        && pkg_cstate >= `ISC_CST_C6;
      // Crystal only stops once every consumer has let go
      gate.xtal_off <= lvl_now == ISC_LVL_THREE
        && pkg_cstate >= `ISC_CST_C10 && ~|idle.xtal_req;
    end
  end

  // Low means deterministic idle; regulator follows it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_floor_n <= 1'b1;
      core_rail_low_voltage_mode <= 1'b0;
    end else begin
      idle_floor_n <= !(lvl_now == ISC_LVL_THREE);
      core_rail_low_voltage_mode <= lvl_now == ISC_LVL_THREE;
    end
  end

  // External clocks only run in the running state
  always_ff @(posedge clk) begin
    if (!rst_n) ext_clk_run <= 1'b0;
    else ext_clk_run <= in_s0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_state <= ISC_SYS_MOFF;
      idle_level <= ISC_LVL_ONE;
    end else begin
      sys_state <= sys_now;
      idle_level <= lvl_now;
    end
  end
endmodule : isc_top
`default_nettype wire

// [verif/isc_assertions.sv]
// Port checker for the idle and sleep state control block
`timescale 1ns/1ps
`default_nettype none
module isc_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire isc_pkg::isc_idle_t idle,
  input wire logic sleep_enable_bit,
  input wire logic [1:0] sleep_type,
  input wire logic power_fail,
  input wire logic power_button_override,
  input wire logic power_return,
  input wire logic mobile_config,
  input wire logic battery_low_n,
  // Outputs
  input wire isc_pkg::isc_gate_t gate,
  input wire logic idle_floor_n,
  input wire logic core_rail_low_voltage_mode,
  input wire logic ext_clk_run,
  input wire logic full_boot,
  input wire isc_pkg::isc_sys_t sys_state,
  input wire isc_pkg::isc_lvl_t idle_level
);
  import isc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence boot_seq;
    (sys_state == ISC_SYS_S5 || sys_state == ISC_SYS_MOFF)
      ##1 sys_state == ISC_SYS_S0;
  endsequence
  // Battery low seen, state already off S0
  sequence hold_seq;
    (mobile_config && !battery_low_n) ##1 sys_state != ISC_SYS_S0;
  endsequence
  a_xtal_level_three: assert property ($rose(gate.xtal_off)
    |-> idle_level == ISC_LVL_THREE) else $error("xtal off early");
  a_base_pll_level: assert property ($rose(gate.base_clk_pll_off)
    |-> idle_level != ISC_LVL_ONE) else $error("base pll off early");
  a_fabric_all_idle: assert property ($rose(gate.fabric_pll_off)
    |-> $past(&{idle.if_idle, idle.ctrl_idle, idle.lane_lowpower}, 2))
    else $error("fabric off");
  a_floor_rail: assert property (
    core_rail_low_voltage_mode == !idle_floor_n) else $error("rail mode");
  a_clk_stop: assert property (sys_state != ISC_SYS_S0 |-> !ext_clk_run)
    else $error("clock runs in sleep");
  a_boot_order: assert property (full_boot |-> boot_seq)
    else $error("full boot misplaced");
  a_moff_deaf: assert property (!power_return ##1 sys_state == ISC_SYS_MOFF
    |=> sys_state == ISC_SYS_MOFF) else $error("left mech off");
  a_battery_hold: assert property (hold_seq |=> sys_state != ISC_SYS_S0)
    else $error("resume with battery low");
  a_sleep_s3: assert property (($rose(sleep_enable_bit)
    && sys_state == ISC_SYS_S0 && sleep_type == 2'h1 && !power_fail
    && !power_button_override) |-> ##2 sys_state == ISC_SYS_S3)
    else $error("no sleep entry");
endmodule : isc_assertions
bind isc_top isc_assertions isc_assertions_inst (.clk, .rst_n, .idle,
  .sleep_enable_bit, .sleep_type, .power_fail, .power_button_override,
  .power_return, .mobile_config, .battery_low_n, .gate, .idle_floor_n,
  .core_rail_low_voltage_mode, .ext_clk_run, .full_boot, .sys_state,
  .idle_level);
`default_nettype wire

// [verif/isc_cpu_model.sv]
// Processor model that sends C-state messages
`timescale 1ns/1ps
`default_nettype none
module isc_cpu_model (
  // Clock
  input wire logic clk,
  // Message to the block
  output var isc_pkg::isc_cmsg_t cmsg
);
  import isc_pkg::*;
  initial cmsg = '0;
  // Payload scrambled once valid drops, so stale values never match
  task automatic send(input logic [2:0] cs);
    @(posedge clk);
    #1;
    cmsg = '{valid: 1'b1, cstate: cs};
    @(posedge clk);
    #1;
    cmsg = '{valid: 1'b0, cstate: ~cs};
  endtask : send
endmodule : isc_cpu_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the idle and sleep state control block
`timescale 1ns/1ps
`default_nettype none
`include "isc_cfg.svh"
module tb;
  import isc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  isc_cmsg_t cmsg;
  isc_idle_t idle = '0;
  logic sleep_enable_bit = 1'b0, wake_event = 1'b0, deep_enter = 1'b0;
  logic deep_exit_ac = 1'b0, power_fail = 1'b0, power_return = 1'b0;
  logic after_power_loss_select = 1'b0, mobile_config = 1'b0;
  logic battery_low_n = 1'b1, power_button_override = 1'b0;
  logic [1:0] sleep_type = 2'h1;
  isc_gate_t gate;
  logic idle_floor_n, core_rail_low_voltage_mode, ext_clk_run, full_boot;
  isc_sys_t sys_state;
  isc_lvl_t idle_level;
  isc_sys_t exp_s[3] = '{ISC_SYS_S3, ISC_SYS_S4, ISC_SYS_S5};
  int n_errors = 0;
  int n_checks = 0;
  int n_boot = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (full_boot === 1'b1) n_boot++;
  isc_top isc_top_inst (.clk, .rst_n, .cmsg, .idle, .sleep_enable_bit,
    .sleep_type, .wake_event, .power_button_override, .deep_enter,
    .deep_exit_ac, .power_fail, .power_return, .after_power_loss_select,
    .mobile_config, .battery_low_n, .gate, .idle_floor_n,
    .core_rail_low_voltage_mode, .ext_clk_run, .full_boot, .sys_state,
    .idle_level);
  isc_cpu_model isc_cpu_model_inst (.clk, .cmsg);
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic s_power;
    pulse(wake_event);
    step(4);
    chk(ISC_SYS_MOFF, sys_state);
    pulse(power_return);
    step(2);
    chk(ISC_SYS_S0, sys_state);
    chk(16'h0001, {15'h0000, ext_clk_run});
    chk(16'h0001, 16'(n_boot));
  endtask : s_power
  task automatic s_idle;
    idle = '{4'h5, 4'hA, 4'h3, 2'h1};
    isc_cpu_model_inst.send(`ISC_CST_C10);
    step(110);
    chk({4'h5, 4'hA, 4'h3, 3'h0}, gate);
    chk(ISC_LVL_ONE, idle_level);
    idle = '{4'hF, 4'hF, 4'hF, 2'h1};
    step(110);
    chk({ISC_LVL_THREE, 4'b0110}, {idle_level, idle_floor_n, gate[2:0]});
    idle.xtal_req = 2'h0;
    step(4);
    chk(4'b1111, {core_rail_low_voltage_mode, gate[2:0]});
    isc_cpu_model_inst.send(`ISC_CST_C0);
    step(5);
    chk({ISC_LVL_ONE, 3'b100}, {idle_level, idle_floor_n,
      gate.base_clk_pll_off, gate.xtal_off});
    isc_cpu_model_inst.send(`ISC_CST_C6);
    step(5);
    chk({ISC_LVL_TWO, 3'b110}, {idle_level, idle_floor_n,
      gate.base_clk_pll_off, gate.xtal_off});
  endtask : s_idle
  task automatic s_sleep;
    for (int i = 0; i < 3; i++) begin
      sleep_type = 2'(i + 1);
      pulse(sleep_enable_bit);
      step(2);
      chk({exp_s[i], 1'b0}, {sys_state, ext_clk_run});
      if (i == 0) begin
        mobile_config = 1'b1;
        battery_low_n = 1'b0;
        pulse(wake_event);
        step(3);
        chk(ISC_SYS_S3, sys_state);
        battery_low_n = 1'b1;
      end
      pulse(wake_event);
      step(2);
      chk(ISC_SYS_S0, sys_state);
    end
    mobile_config = 1'b0;
  endtask : s_sleep
  task automatic s_deep;
    for (int i = 0; i < 3; i++) begin
      sleep_type = 2'(i + 1);
      pulse(sleep_enable_bit);
      step(2);
      pulse(deep_enter);
      step(2);
      chk(ISC_SYS_DEEP, sys_state);
      pulse(deep_exit_ac);
      step(2);
      chk(exp_s[i], sys_state);
      pulse(wake_event);
      step(2);
    end
    chk(16'(3), 16'(n_boot));
  endtask : s_deep
  task automatic s_loss;
    sleep_type = 2'h2;
    after_power_loss_select = 1'b1;
    pulse(sleep_enable_bit);
    step(2);
    pulse(power_fail);
    step(2);
    chk(ISC_SYS_MOFF, sys_state);
    pulse(power_return);
    step(2);
    chk(ISC_SYS_S4, sys_state);
    pulse(wake_event);
    step(2);
    pulse(power_fail);
    step(2);
    pulse(power_return);
    step(2);
    chk(ISC_SYS_S5, sys_state);
  endtask : s_loss
  task automatic s_override;
    pulse(wake_event);
    step(2);
    pulse(power_button_override);
    step(2);
    chk(ISC_SYS_S5, sys_state);
    pulse(wake_event);
    step(2);
    sleep_type = 2'h0;
    pulse(sleep_enable_bit);
    step(2);
    chk(ISC_SYS_S5, sys_state);
    after_power_loss_select = 1'b0;
    mobile_config = 1'b1;
    battery_low_n = 1'b0;
    pulse(power_fail);
    step(2);
    pulse(power_return);
    step(2);
    chk(ISC_SYS_MOFF, sys_state);
    battery_low_n = 1'b1;
    pulse(power_return);
    step(2);
    chk(ISC_SYS_S0, sys_state);
    mobile_config = 1'b0;
  endtask : s_override
  initial begin
    step(10);
    rst_n = 1'b1;
    chk(ISC_SYS_MOFF, sys_state);
    s_power();
    s_idle();
    s_sleep();
    s_deep();
    s_loss();
    s_override();
    report_and_stop();
  end
  // Run needs about 360 cycles; generous margin
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
